//--- sbp_params.svh
// Constants for the system bus pin interface
`ifndef SBP_PARAMS_SVH
`define SBP_PARAMS_SVH
`define SBP_ADDR_W 21
`define SBP_DATA_W 16
`define SBP_NUM_CS 4
`define SBP_CS_IDX_W 2
`define SBP_MCLK_HZ 125000000
`define SBP_CARD_CLK_HZ 8000000
`define SBP_SETUP_CYC 1
`define SBP_MIN_STROBE_CYC 2
`define SBP_CNT_W 4
`define SBP_RESET_ADDR 21'h00_0000
`endif

//--- sbp_pkg.sv
// Types shared by the system bus pin interface
`include "sbp_params.svh"
package sbp_pkg;
  typedef enum logic [2:0] {
    SBP_TGT_DRAM,
    SBP_TGT_BOOT,
    SBP_TGT_PANEL,
    SBP_TGT_CARD_MEM,
    SBP_TGT_CARD_IO
  } sbp_target_t;

  typedef struct packed {
    sbp_target_t target;
    logic write;
    logic [1:0] byte_en;
    logic [`SBP_CS_IDX_W-1:0] chip;
    logic [`SBP_ADDR_W-1:0] addr;
    logic [`SBP_ADDR_W-1:0] col;
    logic [`SBP_DATA_W-1:0] wdata;
  } sbp_req_t;

  typedef struct packed {
    logic [`SBP_ADDR_W-1:0] addr;
    logic [`SBP_DATA_W-1:0] data;
    logic data_oe_n;
    logic panel_select_n;
    logic panel_read_strobe_n;
    logic shared_write_strobe_n;
    logic [`SBP_NUM_CS-1:0] boot_mem_select_n;
    logic boot_mem_read_strobe_n;
    logic [`SBP_NUM_CS-1:0] dram_row_strobe_n;
    logic dram_col_strobe_hi_n;
    logic dram_col_strobe_lo_n;
    logic dram_write_strobe_n;
    logic card_upper_byte_en_n;
    logic card_io_read_n;
    logic card_io_write_n;
    logic card_mem_read_n;
    logic card_mem_write_n;
  } sbp_pins_t;

  typedef enum logic [2:0] {
    SBP_ST_IDLE,
    SBP_ST_SETUP,
    SBP_ST_ROW,
    SBP_ST_COL,
    SBP_ST_STROBE,
    SBP_ST_HOLD
  } sbp_state_t;
endpackage

//--- sbp_sync2.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module sbp_sync2 #(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_r <= {W{RST_VAL}};
      q_out <= {W{RST_VAL}};
    end
    else
    begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule

//--- sbp_card_clk.sv
// Fractional divider making the card clock from the main clock
`timescale 1ns/1ps
`include "sbp_params.svh"
module sbp_card_clk #(
  parameter int unsigned SRC_HZ = `SBP_MCLK_HZ,
  parameter int unsigned OUT_HZ = `SBP_CARD_CLK_HZ
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic card_clk_out
);
  localparam logic [31:0] STEP = 32'(2 * OUT_HZ);
  localparam logic [31:0] MODULUS = 32'(SRC_HZ);

  typedef struct packed {
    logic [31:0] acc;
    logic clk;
  } sbp_div_t;

  sbp_div_t s_r;
  sbp_div_t s_nxt;

  // Edges land on the next source edge at or after the ideal one, so period jitters by one cycle
  always_comb
  begin
    s_nxt = s_r;
    if (s_r.acc + STEP >= MODULUS)
    begin
      s_nxt.acc = s_r.acc + STEP - MODULUS;
      s_nxt.clk = ~s_r.clk;
    end
    else
    begin
      s_nxt.acc = s_r.acc + STEP;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign card_clk_out = s_r.clk;
endmodule

//--- sbp_bus_if.sv
// System bus pin engine: request port on mclk, pins on the bus clock
`timescale 1ns/1ps
// Overview of operation
// - Names ending _n are active low; all other signals active high.
// - Drive a 21-bit address bus toward DRAM, boot memory, panel and card.
// - Shared 16-bit data bus; device drives on writes, target on reads.
// - Panel select asserted for the whole panel access, deasserted otherwise.
// - Panel read strobe asserted only during panel reads.
// - Shared write strobe writes panel when selected, flash otherwise.
// - Four boot memory selects; assert the one being accessed.
// - Boot memory read strobe asserted only during boot memory reads.
// - Four row strobes; selected one asserted once row address is valid.
// - Upper column strobe for high area, lower for low area.
// - DRAM write strobe asserted on DRAM writes, never on reads.
// - Output a continuous 8 MHz card clock.
// - Upper byte enable asserted when card access uses upper lane.
// - Card I/O read strobe only while reading card I/O.
// - Card I/O write strobe only while writing card I/O.
// - Card memory read strobe only while reading card memory.
// - Card memory write strobe only while writing card memory.
// - Card reset output asserted while resetting the card.
`include "sbp_params.svh"
module sbp_bus_if (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic bus_clk_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire sbp_pkg::sbp_req_t req_in,
  output logic rsp_valid_out,
  output logic [`SBP_DATA_W-1:0] rsp_rdata_out,
  input wire logic card_reset_req_in,
  output logic card_irq_out,
  output logic [`SBP_ADDR_W-1:0] addr_out,
  input wire logic [`SBP_DATA_W-1:0] data_in,
  output logic [`SBP_DATA_W-1:0] data_out,
  output logic data_oe_n_out,
  output logic panel_select_n_out,
  output logic panel_read_strobe_n_out,
  output logic shared_write_strobe_n_out,
  input wire logic panel_card_ready_in,
  output logic [`SBP_NUM_CS-1:0] boot_mem_select_n_out,
  output logic boot_mem_read_strobe_n_out,
  output logic [`SBP_NUM_CS-1:0] dram_row_strobe_n_out,
  output logic dram_col_strobe_hi_n_out,
  output logic dram_col_strobe_lo_n_out,
  output logic dram_write_strobe_n_out,
  output logic card_clock_out,
  output logic card_upper_byte_en_n_out,
  output logic card_io_read_n_out,
  output logic card_io_write_n_out,
  output logic card_mem_read_n_out,
  output logic card_mem_write_n_out,
  input wire logic card_no_wait_n_in,
  input wire logic card_irq_in,
  output logic card_reset_out
);
  typedef struct packed {
    logic busy;
    logic req_tgl;
    logic ack_seen;
    logic rsp_valid;
    sbp_pkg::sbp_req_t hold;
  } sbp_mst_t;

  typedef struct packed {
    sbp_pkg::sbp_state_t state;
    logic [`SBP_CNT_W-1:0] cnt;
    logic req_seen;
    logic ack_tgl;
    sbp_pkg::sbp_req_t req;
    logic [`SBP_DATA_W-1:0] rdata;
    logic card_reset;
    sbp_pkg::sbp_pins_t pins;
  } sbp_bst_t;

  localparam logic [`SBP_CNT_W-1:0] SETUP_LAST = `SBP_CNT_W'(`SBP_SETUP_CYC - 1);
  localparam logic [`SBP_CNT_W-1:0] STROBE_LAST = `SBP_CNT_W'(`SBP_MIN_STROBE_CYC - 1);

  sbp_mst_t m_r;
  sbp_mst_t m_nxt;
  sbp_bst_t b_r;
  sbp_bst_t b_nxt;
  logic bus_rst;
  logic req_tgl_s;
  logic ack_tgl_s;
  logic reset_req_s;
  logic ready_s;
  logic no_wait_n_s;
  logic target_ready;

  // Bus-side reset asserts at once, releases on the bus clock
  sbp_sync2 #(.W(1), .RST_VAL(1'b1)) u_bus_rst (
    .clk_in(bus_clk_in),
    .rst_in(rst_in),
    .d_in(1'b0),
    .q_out(bus_rst)
  );

  sbp_sync2 #(.W(1), .RST_VAL(1'b0)) u_req_sync (
    .clk_in(bus_clk_in),
    .rst_in(bus_rst),
    .d_in(m_r.req_tgl),
    .q_out(req_tgl_s)
  );

  sbp_sync2 #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .d_in(b_r.ack_tgl),
    .q_out(ack_tgl_s)
  );

  sbp_sync2 #(.W(1), .RST_VAL(1'b1)) u_rst_req_sync (
    .clk_in(bus_clk_in),
    .rst_in(bus_rst),
    .d_in(card_reset_req_in),
    .q_out(reset_req_s)
  );

  sbp_sync2 #(.W(1), .RST_VAL(1'b0)) u_ready_sync (
    .clk_in(bus_clk_in),
    .rst_in(bus_rst),
    .d_in(panel_card_ready_in),
    .q_out(ready_s)
  );

  sbp_sync2 #(.W(1), .RST_VAL(1'b1)) u_nowait_sync (
    .clk_in(bus_clk_in),
    .rst_in(bus_rst),
    .d_in(card_no_wait_n_in),
    .q_out(no_wait_n_s)
  );

  sbp_sync2 #(.W(1), .RST_VAL(1'b0)) u_irq_sync (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .d_in(card_irq_in),
    .q_out(card_irq_out)
  );

  sbp_card_clk #(.SRC_HZ(`SBP_MCLK_HZ), .OUT_HZ(`SBP_CARD_CLK_HZ)) u_card_clk (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .card_clk_out(card_clock_out)
  );

  // Pin levels for a given state; a single engine means one target at a time
  function automatic sbp_pkg::sbp_pins_t pins_for(input sbp_pkg::sbp_state_t st,
                                                  input sbp_pkg::sbp_req_t rq);
    sbp_pkg::sbp_pins_t p;
    logic in_access;
    logic strobe;
    logic rd;
    logic wr;
    p = '1;
    p.addr = `SBP_RESET_ADDR;
    p.data = '0;
    in_access = (st != sbp_pkg::SBP_ST_IDLE);
    strobe = (st == sbp_pkg::SBP_ST_STROBE) || (st == sbp_pkg::SBP_ST_COL);
    rd = strobe && !rq.write;
    wr = strobe && rq.write;
    if (in_access)
    begin
      p.addr = (st == sbp_pkg::SBP_ST_COL) ? rq.col : rq.addr;
      if (rq.write)
      begin
        p.data = rq.wdata;
        p.data_oe_n = 1'b0;
      end
      case (rq.target)
        sbp_pkg::SBP_TGT_PANEL:
        begin
          p.panel_select_n = 1'b0;
          p.panel_read_strobe_n = !rd;
          p.shared_write_strobe_n = !wr;
        end
        sbp_pkg::SBP_TGT_BOOT:
        begin
          p.boot_mem_select_n[rq.chip] = 1'b0;
          p.boot_mem_read_strobe_n = !rd;
          p.shared_write_strobe_n = !wr;
        end
        sbp_pkg::SBP_TGT_DRAM:
        begin
          if (st != sbp_pkg::SBP_ST_SETUP)
            p.dram_row_strobe_n[rq.chip] = 1'b0;
          p.dram_col_strobe_hi_n = !(strobe && rq.byte_en[1]);
          p.dram_col_strobe_lo_n = !(strobe && rq.byte_en[0]);
          p.dram_write_strobe_n = !(in_access && rq.write);
        end
        sbp_pkg::SBP_TGT_CARD_MEM:
        begin
          p.card_upper_byte_en_n = !(strobe && rq.byte_en[1]);
          p.card_mem_read_n = !rd;
          p.card_mem_write_n = !wr;
        end
        sbp_pkg::SBP_TGT_CARD_IO:
        begin
          p.card_upper_byte_en_n = !(strobe && rq.byte_en[1]);
          p.card_io_read_n = !rd;
          p.card_io_write_n = !wr;
        end
        default:
        begin
          p.data_oe_n = 1'b1;
        end
      endcase
    end
    return p;
  endfunction

  // Request side on mclk; hold register is stable while busy
  always_comb
  begin
    m_nxt = m_r;
    m_nxt.rsp_valid = 1'b0;
    if (ack_tgl_s != m_r.ack_seen)
    begin
      m_nxt.ack_seen = ack_tgl_s;
      m_nxt.busy = 1'b0;
      m_nxt.rsp_valid = 1'b1;
    end
    if (req_valid_in && !m_r.busy)
    begin
      m_nxt.hold = req_in;
      m_nxt.busy = 1'b1;
      m_nxt.req_tgl = ~m_r.req_tgl;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      m_r <= '0;
    else
      m_r <= m_nxt;
  end

  assign req_ready_out = !m_r.busy;
  assign rsp_valid_out = m_r.rsp_valid;
  // Stable since the ack toggle was seen; not sampled until then
  assign rsp_rdata_out = b_r.rdata;

  // Panel waits for ready; card takes ready or no-wait; memories use min count
  always_comb
  begin
    case (b_r.req.target)
      sbp_pkg::SBP_TGT_PANEL: target_ready = ready_s;
      sbp_pkg::SBP_TGT_CARD_MEM,
      sbp_pkg::SBP_TGT_CARD_IO: target_ready = ready_s || !no_wait_n_s;
      default: target_ready = 1'b1;
    endcase
  end

  // Bus engine on the bus clock
  always_comb
  begin
    b_nxt = b_r;
    b_nxt.card_reset = reset_req_s;
    // Saturate so a long wait cannot wrap back under the strobe minimum
    b_nxt.cnt = (b_r.cnt == '1) ? b_r.cnt : b_r.cnt + `SBP_CNT_W'(1);
    case (b_r.state)
      sbp_pkg::SBP_ST_IDLE:
      begin
        b_nxt.cnt = '0;
        if (req_tgl_s != b_r.req_seen)
        begin
          b_nxt.req_seen = req_tgl_s;
          b_nxt.req = m_r.hold;
          b_nxt.state = sbp_pkg::SBP_ST_SETUP;
        end
      end
      sbp_pkg::SBP_ST_SETUP:
      begin
        if (b_r.cnt >= SETUP_LAST)
        begin
          b_nxt.cnt = '0;
          b_nxt.state = (b_r.req.target == sbp_pkg::SBP_TGT_DRAM) ?
                        sbp_pkg::SBP_ST_ROW : sbp_pkg::SBP_ST_STROBE;
        end
      end
      sbp_pkg::SBP_ST_ROW:
      begin
        // Row strobe falls one cycle after the row address settles
        b_nxt.cnt = '0;
        b_nxt.state = sbp_pkg::SBP_ST_COL;
      end
      sbp_pkg::SBP_ST_COL,
      sbp_pkg::SBP_ST_STROBE:
      begin
        // No timeout: a target that never readies stalls the bus
        if (b_r.cnt >= STROBE_LAST && target_ready)
        begin
          b_nxt.rdata = data_in;
          b_nxt.state = sbp_pkg::SBP_ST_HOLD;
        end
      end
      sbp_pkg::SBP_ST_HOLD:
      begin
        b_nxt.ack_tgl = ~b_r.ack_tgl;
        b_nxt.state = sbp_pkg::SBP_ST_IDLE;
      end
      default:
      begin
        b_nxt.state = sbp_pkg::SBP_ST_IDLE;
      end
    endcase
    b_nxt.pins = pins_for(b_nxt.state, b_nxt.req);
  end

  always_ff @(posedge bus_clk_in or posedge bus_rst)
  begin
    if (bus_rst)
    begin
      b_r <= '0;
      b_r.state <= sbp_pkg::SBP_ST_IDLE;
      b_r.card_reset <= 1'b1;
      b_r.pins <= '1;
      b_r.pins.addr <= `SBP_RESET_ADDR;
      b_r.pins.data <= '0;
    end
    else
    begin
      b_r <= b_nxt;
    end
  end

  assign addr_out = b_r.pins.addr;
  assign data_out = b_r.pins.data;
  assign data_oe_n_out = b_r.pins.data_oe_n;
  assign panel_select_n_out = b_r.pins.panel_select_n;
  assign panel_read_strobe_n_out = b_r.pins.panel_read_strobe_n;
  assign shared_write_strobe_n_out = b_r.pins.shared_write_strobe_n;
  assign boot_mem_select_n_out = b_r.pins.boot_mem_select_n;
  assign boot_mem_read_strobe_n_out = b_r.pins.boot_mem_read_strobe_n;
  assign dram_row_strobe_n_out = b_r.pins.dram_row_strobe_n;
  assign dram_col_strobe_hi_n_out = b_r.pins.dram_col_strobe_hi_n;
  assign dram_col_strobe_lo_n_out = b_r.pins.dram_col_strobe_lo_n;
  assign dram_write_strobe_n_out = b_r.pins.dram_write_strobe_n;
  assign card_upper_byte_en_n_out = b_r.pins.card_upper_byte_en_n;
  assign card_io_read_n_out = b_r.pins.card_io_read_n;
  assign card_io_write_n_out = b_r.pins.card_io_write_n;
  assign card_mem_read_n_out = b_r.pins.card_mem_read_n;
  assign card_mem_write_n_out = b_r.pins.card_mem_write_n;
  assign card_reset_out = b_r.card_reset;
endmodule

//--- sbp_checker.sv
// Port-level assertions for the bus pin engine
`timescale 1ns/1ps
`include "sbp_params.svh"
module sbp_checker (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic bus_clk_in,
  input wire logic data_oe_n_out,
  input wire logic panel_select_n_out,
  input wire logic panel_read_strobe_n_out,
  input wire logic shared_write_strobe_n_out,
  input wire logic [`SBP_NUM_CS-1:0] boot_mem_select_n_out,
  input wire logic boot_mem_read_strobe_n_out,
  input wire logic [`SBP_NUM_CS-1:0] dram_row_strobe_n_out,
  input wire logic dram_col_strobe_hi_n_out,
  input wire logic dram_col_strobe_lo_n_out,
  input wire logic dram_write_strobe_n_out,
  input wire logic card_clock_out,
  input wire logic card_io_read_n_out,
  input wire logic card_io_write_n_out,
  input wire logic card_mem_read_n_out,
  input wire logic card_mem_write_n_out
);
  logic [12:0] tgt_sel;
  // Each of these may let a target drive the shared data lines
  assign tgt_sel = ~{panel_select_n_out, boot_mem_select_n_out, dram_row_strobe_n_out,
    card_io_read_n_out, card_io_write_n_out, card_mem_read_n_out, card_mem_write_n_out};
  default clocking @(posedge bus_clk_in);
  endclocking
  default disable iff (rst_in);
  AST_ONE_TARGET: assert property ($onehot0(tgt_sel))
    else $error("Two targets selected");
  AST_PANEL_CS: assert property ($fell(panel_select_n_out) |-> !panel_select_n_out[*4])
    else $error("Panel select too short");
  AST_PANEL_RD: assert property (
    !panel_read_strobe_n_out |-> !panel_select_n_out && data_oe_n_out)
    else $error("Panel read strobe outside panel read");
  AST_SHARED_WR: assert property (
    !shared_write_strobe_n_out |-> !data_oe_n_out
      && (!panel_select_n_out || boot_mem_select_n_out != 4'hf))
    else $error("Shared write strobe without panel or flash write");
  AST_BOOT_RD: assert property (
    !boot_mem_read_strobe_n_out |-> $onehot(~boot_mem_select_n_out) && data_oe_n_out)
    else $error("Boot read strobe outside boot read");
  AST_COL_ROW: assert property (
    !(dram_col_strobe_hi_n_out && dram_col_strobe_lo_n_out)
      |-> $onehot(~dram_row_strobe_n_out) && $past(dram_row_strobe_n_out) != 4'hf)
    else $error("Column strobe without prior row strobe");
  AST_DRAM_WR: assert property (!dram_write_strobe_n_out |-> !data_oe_n_out)
    else $error("DRAM write strobe during read");
  AST_CARD_WR: assert property (
    !(card_io_write_n_out && card_mem_write_n_out) |-> !data_oe_n_out)
    else $error("Card write strobe while not driving");
  AST_CARD_RD: assert property (
    !(card_io_read_n_out && card_mem_read_n_out) |-> data_oe_n_out)
    else $error("Card read strobe while driving");
  AST_CARD_CLOCK: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(card_clock_out) |-> card_clock_out[*7] ##[1:2] !card_clock_out)
    else $error("Card clock high phase wrong");
  cover property (!panel_read_strobe_n_out);
  cover property (!dram_write_strobe_n_out && !dram_col_strobe_lo_n_out);
  cover property (!card_io_read_n_out);
endmodule

//--- sbp_target_model.sv
// Behavioural targets on the far side of the bus pins
`timescale 1ns/1ps
`include "sbp_params.svh"
module sbp_target_model (
  input wire logic bus_clk_in,
  input wire logic rst_in,
  input wire sbp_pkg::sbp_pins_t pins_in,
  input wire logic [7:0] wait_in,
  input wire logic irq_cmd_in,
  output logic [`SBP_DATA_W-1:0] data_out,
  output logic ready_out,
  output logic no_wait_n_out,
  output logic irq_out
);
  logic [7:0] cnt_r;
  logic card, rd;
  assign card = !(pins_in.card_io_read_n && pins_in.card_io_write_n
    && pins_in.card_mem_read_n && pins_in.card_mem_write_n);
  assign rd = pins_in.data_oe_n && !(pins_in.panel_read_strobe_n
    && pins_in.boot_mem_read_strobe_n && pins_in.dram_col_strobe_hi_n
    && pins_in.dram_col_strobe_lo_n && pins_in.card_io_read_n && pins_in.card_mem_read_n);
  assign irq_out = irq_cmd_in;
  always_ff @(posedge bus_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_r <= 8'h00;
      ready_out <= 1'b0;
      no_wait_n_out <= 1'b1;
      data_out <= 16'h0000;
    end
    else
    begin
      if (!(card || !pins_in.panel_select_n))
        cnt_r <= 8'h00;
      else if (cnt_r != 8'hff)
        cnt_r <= cnt_r + 8'h01;
      ready_out <= !pins_in.panel_select_n && cnt_r >= wait_in;
      no_wait_n_out <= !(card && cnt_r >= wait_in);
      // Released lines toggle every cycle so a capture one cycle late does not match
      data_out <= rd ? ~pins_in.addr[15:0] : ~data_out;
    end
  end
endmodule

//--- sbp_tb.sv
// Self-checking bench for the bus pin engine
`timescale 1ns/1ps
`include "sbp_params.svh"
module testbench;
  typedef struct packed {
    logic [2:0] t;
    logic w;
    logic [1:0] be;
    logic [1:0] ch;
    logic [19:0] exp;
  } sbp_row_t;
  // Target code as in sbp_target_t; exp bits high where the strobe was seen low:
  // panel cs/rd, shared wr, boot cs[3:0]/rd, row[3:0], col hi/lo, dram wr, upper, io, mem
  sbp_row_t rows [10] = '{
    '{3'h2, 1'h0, 2'h3, 2'h0, 20'hc_0000}, '{3'h2, 1'h1, 2'h3, 2'h0, 20'ha_0000},
    '{3'h1, 1'h0, 2'h3, 2'h2, 20'h0_9000}, '{3'h1, 1'h1, 2'h3, 2'h3, 20'h3_0000},
    '{3'h0, 1'h0, 2'h2, 2'h1, 20'h0_0280}, '{3'h0, 1'h1, 2'h1, 2'h0, 20'h0_0160},
    '{3'h4, 1'h0, 2'h3, 2'h0, 20'h0_0018}, '{3'h4, 1'h1, 2'h1, 2'h0, 20'h0_0004},
    '{3'h3, 1'h0, 2'h2, 2'h0, 20'h0_0012}, '{3'h3, 1'h1, 2'h3, 2'h0, 20'h0_0011}};
  logic mclk_in, rst_in, bus_clk_in, req_valid, card_rst_req, irq_cmd, mirq;
  logic req_ready, rsp_valid, card_irq, oe_n, pnl_cs, pnl_rd, sh_wr, boot_rd, chi, clo, dwr;
  logic cclk, ub, iord, iowr, mrd, mwr, crst, rdy, nw_n;
  logic [3:0] boot_cs, row;
  logic [20:0] addr;
  logic [15:0] rdata, dout, dbus, mdata, wseen, rd;
  logic [7:0] wait_cyc;
  logic [19:0] seen;
  sbp_pkg::sbp_req_t req, r;
  sbp_pkg::sbp_pins_t pins;
  int num_errors = 0;
  int checked = 0;
  int nclk = 0;
  int nclk0 = 0;
  assign dbus = oe_n ? mdata : dout;
  assign pins = {addr, dout, oe_n, pnl_cs, pnl_rd, sh_wr, boot_cs, boot_rd, row, chi, clo, dwr,
    ub, iord, iowr, mrd, mwr};
  sbp_bus_if dut (.mclk_in(mclk_in), .rst_in(rst_in), .bus_clk_in(bus_clk_in),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_in(req),
    .rsp_valid_out(rsp_valid), .rsp_rdata_out(rdata), .card_reset_req_in(card_rst_req),
    .card_irq_out(card_irq), .addr_out(addr), .data_in(dbus), .data_out(dout),
    .data_oe_n_out(oe_n), .panel_select_n_out(pnl_cs), .panel_read_strobe_n_out(pnl_rd),
    .shared_write_strobe_n_out(sh_wr), .panel_card_ready_in(rdy),
    .boot_mem_select_n_out(boot_cs), .boot_mem_read_strobe_n_out(boot_rd),
    .dram_row_strobe_n_out(row), .dram_col_strobe_hi_n_out(chi), .dram_col_strobe_lo_n_out(clo),
    .dram_write_strobe_n_out(dwr), .card_clock_out(cclk), .card_upper_byte_en_n_out(ub),
    .card_io_read_n_out(iord), .card_io_write_n_out(iowr), .card_mem_read_n_out(mrd),
    .card_mem_write_n_out(mwr), .card_no_wait_n_in(nw_n), .card_irq_in(mirq),
    .card_reset_out(crst));
  sbp_target_model tgt (.bus_clk_in(bus_clk_in), .rst_in(rst_in), .pins_in(pins),
    .wait_in(wait_cyc), .irq_cmd_in(irq_cmd), .data_out(mdata), .ready_out(rdy),
    .no_wait_n_out(nw_n), .irq_out(mirq));
  initial
  begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  // Odd offset keeps the link clock out of phase with the main clock
  initial
  begin
    bus_clk_in = 1'b0;
    #1.3;
    forever #3 bus_clk_in = ~bus_clk_in;
  end
  always @(posedge cclk) nclk++;
  always @(posedge bus_clk_in)
  begin
    // Cleared while a request is offered, before its pins can move
    seen <= req_valid ? 20'h0_0000 : seen | ~{pnl_cs, pnl_rd, sh_wr, boot_cs, boot_rd, row,
      chi, clo, dwr, ub, iord, iowr, mrd, mwr};
    if (!oe_n)
      wseen <= dout;
  end
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask
  task automatic results;
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic xfer(input sbp_pkg::sbp_req_t q, input logic [7:0] w);
    int n;
    n = 0;
    @(posedge mclk_in);
    req <= q;
    req_valid <= 1'b1;
    wait_cyc <= w;
    #1;
    chk(req_ready === 1'b1, "not ready");
    @(posedge mclk_in);
    req_valid <= 1'b0;
    while (n < 2000 && rsp_valid !== 1'b1)
    begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    rd = rdata;
    chk(n < 2000, "no response");
  endtask
  initial
  begin
    rst_in = 1'b1;
    req_valid = 1'b0;
    req = '0;
    wait_cyc = 8'h00;
    card_rst_req = 1'b0;
    irq_cmd = 1'b0;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (10) @(posedge mclk_in);
    foreach (rows[i])
    begin
      r = '{sbp_pkg::sbp_target_t'(rows[i].t), rows[i].w, rows[i].be, rows[i].ch,
        21'h1_0a00 + 21'(i), 21'h0_0300 + 21'(i), 16'h5a00 + 16'(i)};
      xfer(r, 8'(i * 3));
      chk(seen === rows[i].exp, "strobes");
      if (r.write)
        chk(wseen === r.wdata, "write data");
      else
        chk(rd === ~(i < 6 && i > 3 ? r.col[15:0] : r.addr[15:0]), "read data");
    end
    // A panel with a 255-cycle wait stalls the engine until reset
    @(posedge mclk_in);
    req.target <= sbp_pkg::SBP_TGT_PANEL;
    req_valid <= 1'b1;
    wait_cyc <= 8'hff;
    @(posedge mclk_in);
    req_valid <= 1'b0;
    repeat (20) @(posedge mclk_in);
    chk(pnl_cs === 1'b0 && rsp_valid === 1'b0, "panel did not wait");
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk({pnl_cs, pnl_rd, oe_n, crst, req_ready} === 5'h1f, "pins in reset");
    rst_in <= 1'b0;
    card_rst_req <= 1'b1;
    repeat (10) @(posedge mclk_in);
    chk(crst === 1'b1, "card reset");
    card_rst_req <= 1'b0;
    irq_cmd <= 1'b1;
    repeat (10) @(posedge mclk_in);
    chk(crst === 1'b0 && card_irq === 1'b1, "reset release or irq");
    irq_cmd <= 1'b0;
    nclk0 = nclk;
    repeat (1000) @(posedge mclk_in);
    chk(nclk - nclk0 >= 63 && nclk - nclk0 <= 65 && card_irq === 1'b0,
      "card clock or irq");
    results();
  end
  initial
  begin
    #100000;
    num_errors++;
    results();
  end
endmodule
bind sbp_bus_if sbp_checker chk_i (.mclk_in(mclk_in), .rst_in(rst_in), .bus_clk_in(bus_clk_in),
  .data_oe_n_out(data_oe_n_out), .panel_select_n_out(panel_select_n_out),
  .panel_read_strobe_n_out(panel_read_strobe_n_out),
  .shared_write_strobe_n_out(shared_write_strobe_n_out),
  .boot_mem_select_n_out(boot_mem_select_n_out),
  .boot_mem_read_strobe_n_out(boot_mem_read_strobe_n_out),
  .dram_row_strobe_n_out(dram_row_strobe_n_out),
  .dram_col_strobe_hi_n_out(dram_col_strobe_hi_n_out),
  .dram_col_strobe_lo_n_out(dram_col_strobe_lo_n_out),
  .dram_write_strobe_n_out(dram_write_strobe_n_out), .card_clock_out(card_clock_out),
  .card_io_read_n_out(card_io_read_n_out), .card_io_write_n_out(card_io_write_n_out),
  .card_mem_read_n_out(card_mem_read_n_out), .card_mem_write_n_out(card_mem_write_n_out));
